// [design/mid_pkg.sv]
// package: constants, decoded-word layout and states of the instruction core
package mid_pkg;
   // =========================================================
   // instruction word fields
   localparam logic [13:0] NOP_WORD  = 14'h0000;
   localparam logic [1:0]  FAM_BYTE  = 2'h0;
   localparam logic [1:0]  FAM_BIT   = 2'h1;
   localparam logic [1:0]  FAM_JUMP  = 2'h2;
   localparam logic [1:0]  FAM_CONST = 2'h3;
   // =========================================================
   // byte operation codes
   localparam logic [3:0] OP_CTRL      = 4'h0;
   localparam logic [3:0] OP_ZERO      = 4'h1;
   localparam logic [3:0] OP_SUB       = 4'h2;
   localparam logic [3:0] OP_MINUS     = 4'h3;
   localparam logic [3:0] OP_OR        = 4'h4;
   localparam logic [3:0] OP_AND       = 4'h5;
   localparam logic [3:0] OP_XOR       = 4'h6;
   localparam logic [3:0] OP_ADD       = 4'h7;
   localparam logic [3:0] OP_COPY      = 4'h8;
   localparam logic [3:0] OP_INVERT    = 4'h9;
   localparam logic [3:0] OP_PLUS      = 4'ha;
   localparam logic [3:0] OP_MINUS_SKP = 4'hb;
   localparam logic [3:0] OP_ROT_DOWN  = 4'hc;
   localparam logic [3:0] OP_ROT_UP    = 4'hd;
   localparam logic [3:0] OP_NIB_EXCH  = 4'he;
   localparam logic [3:0] OP_PLUS_SKP  = 4'hf;
   // =========================================================
   // control words (low seven bits with byte code 0000, d = 0)
   localparam logic [6:0] CW_RETURN   = 7'h08;
   localparam logic [6:0] CW_INT_EXIT = 7'h09;
   localparam logic [6:0] CW_STANDBY  = 7'h63;
   localparam logic [6:0] CW_KICK     = 7'h64;
   // =========================================================
   // core constants
   localparam logic [6:0] PORT_ADDR  = 7'h05;
   localparam logic [1:0] Q_LAST     = 2'h3;
   localparam int         STACK_DEP  = 8;
   localparam int         FILE_DEP   = 128;
   localparam logic [10:0] COUNTER_RST = 11'h000;
   localparam logic [7:0] ACC_RST    = 8'h00;
   // =========================================================
   // register map
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STAT   = 8'h04;
   localparam int         CTRL_RUN   = 0;
   localparam int         CTRL_WAKE  = 1;
   localparam logic       RUN_RST    = 1'b0;

   typedef enum logic [1:0] {st_halt, st_run, st_sleep} mid_state_e;

   typedef struct packed {
      logic [1:0]  fam;
      logic [3:0]  op;
      logic        d;
      logic [2:0]  b;
      logic [6:0]  f;
      logic [7:0]  k;
      logic [10:0] t;
   } mid_dec_s;
endpackage

// [design/mid_core.sv]
// instruction sequencer for the 14-bit word core, with an apb register slave
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - each instruction is one 14-bit word: family, opcode and operand fields
// - destination bit 0 writes the accumulator, 1 writes the file register
// - register select is a seven-bit file address 0x00 to 0x7f
// - 8-bit constants; 11-bit jump targets, 100 call, 101 jump, two cycles
// - one instruction cycle spans four clock periods
// - one cycle normally, two on skip or branch, second is a no-op
// - every file-naming instruction reads the register before writing it
// - add, subtract, plus one, minus one byte codes and their flags
// - or, and, xor, invert and copy update the zero flag only
// - rotates through carry update carry; nibble exchange touches no flag
// - minus/plus one with skip when result is zero, flags untouched
// - clear register or accumulator sets zero; store accumulator; no-op pattern
// - bit clear and bit set on a selected bit, no flags
// - bit tests skip next instruction when bit clear or set
// - constant or, and update zero; constant load touches no flag
// - constant add and subtract-accumulator update carry, nibble carry, zero
// - return with constant, return and interrupt exit take two cycles
// - standby and watchdog kick take one cycle; kick sets both status bits, standby sets expired and clears sleep
// - the port register reads from the pins, not from its latch
module mid_core
   import mid_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [10:0] prog_addr,
   input  wire logic [13:0] prog_data,
   input  wire logic [7:0]  port_pins,
   output logic      [7:0]  port_out,
   input  wire logic        wake,
   output logic             file_rd,
   output logic             file_wr,
   output logic             wdt_clear,
   output logic             asleep
);
   // =========================================================
   // helpers
   function automatic mid_dec_s decode(input logic [13:0] w);
      mid_dec_s r;
      r.fam = w[13:12];
      r.op  = w[11:8];
      r.d   = w[7];
      r.b   = w[9:7];
      r.f   = w[6:0];
      r.k   = w[7:0];
      r.t   = w[10:0];
      return r;
   endfunction

   // {carry, nibble carry, sum}
   function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      return {s[8], h[4], s[7:0]};
   endfunction

   // =========================================================
   // core state
   mid_state_e  state, next_state;
   logic [1:0]  q, next_q;
   logic [10:0] program_counter, next_program_counter;
   logic [13:0] ir, next_ir;
   logic [7:0]  acc, next_acc;
   logic        carry, next_carry;
   logic        nibble_overflow_flag, next_nibble_overflow_flag;
   logic        zflag, next_zflag;
   logic        expired_flag, next_expired_flag;
   logic        sleep_flag, next_sleep_flag;
   logic [10:0] stk [STACK_DEP];
   logic [10:0] next_stk [STACK_DEP];
   logic [2:0]  sp, next_sp;
   logic [7:0]  file_mem [FILE_DEP];
   logic [7:0]  next_file_mem [FILE_DEP];
   logic        next_file_rd, next_file_wr, next_wdt_clear, next_asleep;
   logic        run, next_run;
   logic        sw_wake, next_sw_wake;
   mid_dec_s    dec;
   logic        tick;
   logic [7:0]  rv;
   logic [7:0]  res;
   logic [7:0]  mask;
   logic [9:0]  sum;
   logic        wr_f, wr_acc, flush, names_file;

   assign dec  = decode(ir);
   assign tick = (state == st_run) && (q == Q_LAST);
   assign mask = 8'h01 << dec.b;
   // port reads see the pins so externally driven inputs are written back as seen
   assign rv   = (dec.f == PORT_ADDR) ? port_pins : file_mem[dec.f];

   // =========================================================
   // execute
   always_comb begin
      next_state                = state;
      next_q                    = (state == st_run) ? q + 2'h1 : 2'h0;
      next_program_counter      = program_counter;
      next_ir                   = ir;
      next_acc                  = acc;
      next_carry                = carry;
      next_nibble_overflow_flag = nibble_overflow_flag;
      next_zflag                = zflag;
      next_expired_flag         = expired_flag;
      next_sleep_flag           = sleep_flag;
      next_stk                  = stk;
      next_sp                   = sp;
      next_file_mem             = file_mem;
      next_wdt_clear            = 1'b0;
      res                       = rv;
      sum                       = 10'h000;
      wr_f                      = 1'b0;
      wr_acc                    = 1'b0;
      flush                     = 1'b0;
      names_file = (dec.fam == FAM_BIT) ||
                   ((dec.fam == FAM_BYTE) && !((dec.op == OP_CTRL || dec.op == OP_ZERO) && !dec.d));
      if (tick) begin
         next_program_counter = program_counter + 11'h001;
         unique case (dec.fam)
            FAM_BYTE: begin
               wr_f   = dec.d;
               wr_acc = !dec.d;
               unique case (dec.op)
                  OP_CTRL: begin
                     res    = acc;
                     wr_acc = 1'b0;
                     if (!dec.d) begin
                        // other words in this slot, the no-op pattern included, do nothing
                        if (dec.f == CW_RETURN || dec.f == CW_INT_EXIT) begin
                           next_sp              = sp - 3'h1;
                           next_program_counter = stk[sp - 3'h1];
                           flush                = 1'b1;
                        end else if (dec.f == CW_STANDBY) begin
                           next_sleep_flag   = 1'b0;
                           next_expired_flag = 1'b1;
                           next_wdt_clear    = 1'b1;
                           next_state        = st_sleep;
                        end else if (dec.f == CW_KICK) begin
                           next_sleep_flag   = 1'b1;
                           next_expired_flag = 1'b1;
                           next_wdt_clear    = 1'b1;
                        end
                     end
                  end
                  OP_ZERO: begin
                     res        = 8'h00;
                     next_zflag = 1'b1;
                  end
                  OP_ADD, OP_SUB: begin
                     sum = (dec.op == OP_ADD) ? add8(rv, acc, 1'b0) : add8(rv, ~acc, 1'b1);
                     res = sum[7:0];
                     next_carry                = sum[9];
                     next_nibble_overflow_flag = sum[8];
                     next_zflag                = (sum[7:0] == 8'h00);
                  end
                  OP_MINUS, OP_PLUS: begin
                     res        = (dec.op == OP_PLUS) ? rv + 8'h01 : rv - 8'h01;
                     next_zflag = (res == 8'h00);
                  end
                  OP_OR, OP_AND, OP_XOR, OP_INVERT, OP_COPY: begin
                     unique case (dec.op)
                        OP_OR:     res = rv | acc;
                        OP_AND:    res = rv & acc;
                        OP_XOR:    res = rv ^ acc;
                        OP_INVERT: res = ~rv;
                        default:   res = rv;
                     endcase
                     next_zflag = (res == 8'h00);
                  end
                  OP_ROT_UP: begin
                     res        = {rv[6:0], carry};
                     next_carry = rv[7];
                  end
                  OP_ROT_DOWN: begin
                     res        = {carry, rv[7:1]};
                     next_carry = rv[0];
                  end
                  OP_NIB_EXCH: res = {rv[3:0], rv[7:4]};
                  OP_MINUS_SKP, OP_PLUS_SKP: begin
                     res   = (dec.op == OP_PLUS_SKP) ? rv + 8'h01 : rv - 8'h01;
                     flush = (res == 8'h00);
                  end
               endcase
            end
            FAM_BIT: begin
               unique case (dec.op[3:2])
                  2'h0: begin
                     res  = rv & ~mask;
                     wr_f = 1'b1;
                  end
                  2'h1: begin
                     res  = rv | mask;
                     wr_f = 1'b1;
                  end
                  2'h2: flush = ((rv & mask) == 8'h00);
                  2'h3: flush = ((rv & mask) != 8'h00);
               endcase
            end
            FAM_JUMP: begin
               if (!dec.op[3]) begin
                  next_stk[sp] = program_counter;
                  next_sp      = sp + 3'h1;
               end
               next_program_counter = dec.t;
               flush   = 1'b1;
            end
            FAM_CONST: begin
               res    = dec.k;
               wr_acc = 1'b1;
               if (dec.op[3:2] == 2'h0) begin
                  res = dec.k;
               end else if (dec.op[3:2] == 2'h1) begin
                  next_sp              = sp - 3'h1;
                  next_program_counter = stk[sp - 3'h1];
                  flush                = 1'b1;
               end else if (dec.op == 4'h8 || dec.op == 4'h9) begin
                  res        = dec.op[0] ? (acc & dec.k) : (acc | dec.k);
                  next_zflag = (res == 8'h00);
               end else if (dec.op[3:2] == 2'h3) begin
                  sum = dec.op[1] ? add8(dec.k, acc, 1'b0) : add8(dec.k, ~acc, 1'b1);
                  res = sum[7:0];
                  next_carry                = sum[9];
                  next_nibble_overflow_flag = sum[8];
                  next_zflag                = (sum[7:0] == 8'h00);
               end else begin
                  wr_acc = 1'b0;
               end
            end
         endcase
         if (wr_f) begin
            next_file_mem[dec.f] = res;
         end
         if (wr_acc) begin
            next_acc = res;
         end
         // discarded prefetch becomes the no-op second cycle
         next_ir = flush ? NOP_WORD : prog_data;
         if (!run && next_state == st_run) begin
            next_state = st_halt;
         end
      end
      unique case (state)
         st_halt:  if (run) next_state = st_run;
         st_sleep: if (wake || sw_wake) next_state = st_run;
         st_run:   ;
      endcase
      // read strobe early in the cycle, even for write-only forms
      next_file_rd = (state == st_run) && (q == 2'h0) && names_file;
      next_file_wr = wr_f;
      next_asleep  = (next_state == st_sleep);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state                <= st_halt;
         q                    <= 2'h0;
         program_counter      <= COUNTER_RST;
         ir                   <= NOP_WORD;
         acc                  <= ACC_RST;
         carry                <= 1'b0;
         nibble_overflow_flag <= 1'b0;
         zflag                <= 1'b0;
         expired_flag         <= 1'b1;
         sleep_flag           <= 1'b1;
         sp                   <= 3'h0;
         file_rd              <= 1'b0;
         file_wr              <= 1'b0;
         wdt_clear            <= 1'b0;
         asleep               <= 1'b0;
         for (int i = 0; i < STACK_DEP; i++) begin
            stk[i] <= COUNTER_RST;
         end
         for (int i = 0; i < FILE_DEP; i++) begin
            file_mem[i] <= 8'h00;
         end
      end else begin
         state                <= next_state;
         q                    <= next_q;
         program_counter      <= next_program_counter;
         ir                   <= next_ir;
         acc                  <= next_acc;
         carry                <= next_carry;
         nibble_overflow_flag <= next_nibble_overflow_flag;
         zflag                <= next_zflag;
         expired_flag         <= next_expired_flag;
         sleep_flag           <= next_sleep_flag;
         sp                   <= next_sp;
         file_rd              <= next_file_rd;
         file_wr              <= next_file_wr;
         wdt_clear            <= next_wdt_clear;
         asleep               <= next_asleep;
         stk                  <= next_stk;
         file_mem             <= next_file_mem;
      end
   end

   assign prog_addr = program_counter;
   assign port_out  = file_mem[PORT_ADDR];

   // =========================================================
   // apb slave, one wait state
   logic [31:0] next_prdata;
   logic        next_pready, next_pslverr;
   logic        acc_ph, mapped;

   assign acc_ph = psel && penable;
   assign mapped = (paddr == REG_CTRL) || (paddr == REG_STAT);

   always_comb begin
      next_pready  = acc_ph && !pready;
      next_pslverr = acc_ph && !pready && !mapped;
      next_prdata  = 32'h0000_0000;
      next_run     = run;
      next_sw_wake = 1'b0;
      if (acc_ph && !pready && !pwrite) begin
         if (paddr == REG_CTRL) begin
            next_prdata[CTRL_RUN] = run;
         end else if (paddr == REG_STAT) begin
            next_prdata = {5'h00, program_counter, acc, 2'h0, asleep, expired_flag, sleep_flag,
                           zflag, nibble_overflow_flag, carry};
         end
      end
      // writes land on the edge that samples pready high
      if (acc_ph && pready && pwrite && paddr == REG_CTRL) begin
         next_run     = pwdata[CTRL_RUN];
         next_sw_wake = pwdata[CTRL_WAKE];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         run     <= RUN_RST;
         sw_wake <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         run     <= next_run;
         sw_wake <= next_sw_wake;
      end
   end

   // =========================================================
   // checks
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_quarter_spacing: assert property (tick |=> !tick [*3])
      else $error("instruction cycle shorter than four clocks");
   chk_dest_acc: assert property (tick && dec.fam == FAM_BYTE && dec.op == OP_ADD && !dec.d
                                  |=> acc == $past(acc) + $past(rv) && !file_wr)
      else $error("add to accumulator wrong");
   chk_dest_file: assert property (tick && dec.fam == FAM_BYTE && dec.op == OP_INVERT && dec.d
                                   |=> file_wr && acc == $past(acc))
      else $error("result not sent to file register");
   chk_read_first: assert property (tick && names_file |-> $past(file_rd, 2))
      else $error("file register not read before write");
   chk_flush_nop: assert property (tick && flush |=> ir == NOP_WORD ##3 tick || state != st_run)
      else $error("prefetched word not discarded");
   chk_call_target: assert property (tick && dec.fam == FAM_JUMP && !dec.op[3]
                                     |=> program_counter == $past(dec.t) && sp == $past(sp) + 3'h1)
      else $error("call did not branch and push");
   chk_standby_flags: assert property (tick && dec.fam == FAM_BYTE && dec.op == OP_CTRL && !dec.d
                                       && dec.f == CW_STANDBY |=> !sleep_flag && expired_flag && asleep)
      else $error("standby status wrong");
   chk_port_pins: assert property (tick && dec.fam == FAM_BYTE && dec.op == OP_COPY && !dec.d
                                   && dec.f == PORT_ADDR |=> acc == $past(port_pins))
      else $error("port read not from pins");
   chk_exch_flags: assert property (tick && dec.fam == FAM_BYTE && dec.op == OP_NIB_EXCH
                                    |=> carry == $past(carry) && zflag == $past(zflag))
      else $error("nibble exchange changed flags");
endmodule

// [bench/mid_prog_mem.sv]
// program memory model that feeds instruction words to the core
`timescale 1ns/1ps
module mid_prog_mem
   import mid_pkg::*;
#(
   parameter int LAT = 1
)
(
   input  wire logic        pclk,
   input  wire logic [10:0] prog_addr,
   output logic      [13:0] prog_data
);
   // =========================================================
   // storage, loaded by the bench before the core runs
   logic [13:0] mem [0:2047];
   logic [10:0] last_addr;
   int          wait_cnt;

   initial begin
      prog_data = NOP_WORD;
      last_addr = 11'h7ff;
      wait_cnt  = 0;
   end

   // =========================================================
   // slow answer: stale data is inverted every clock so nothing early can pass
   always @(posedge pclk) begin
      if (prog_addr !== last_addr) begin
         last_addr <= prog_addr;
         wait_cnt  <= 0;
         prog_data <= ~prog_data;
      end else if (wait_cnt < LAT) begin
         wait_cnt  <= wait_cnt + 1;
         prog_data <= (wait_cnt + 1 == LAT) ? mem[prog_addr] : ~prog_data;
      end
   end
endmodule

// [bench/testbench.sv]
// self-checking bench: apb register access and one program run on the core
`timescale 1ns/1ps
module testbench
   import mid_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wake;
   logic        file_rd, file_wr, wdt_clear, asleep;
   logic [7:0]  paddr, port_pins, port_out;
   logic [31:0] pwdata, prdata, rd;
   logic [10:0] prog_addr;
   logic [13:0] prog_data;
   logic        err;
   int          errors, total_checks, n_rd, n_wr, n_wdt, n;
   // don't-care bits set to one in words 0 and 1
   // subroutine at 0x0c: port copy, invert, add to acc, nibble exchange, zero acc, return
   logic [13:0] prog [18] = '{14'h330f, 14'h3ff1, 14'h00a0, 14'h0fa0, 14'h0ba0, 14'h3055, 14'h1485,
                              14'h1c05, 14'h30aa, 14'h200c, 14'h0063, 14'h280b, 14'h0805, 14'h09a0,
                              14'h0720, 14'h0e20, 14'h0100, 14'h343c};

   mid_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .prog_addr(prog_addr), .prog_data(prog_data), .port_pins(port_pins), .port_out(port_out),
      .wake(wake), .file_rd(file_rd), .file_wr(file_wr), .wdt_clear(wdt_clear), .asleep(asleep));
   mid_prog_mem pm (.pclk(pclk), .prog_addr(prog_addr), .prog_data(prog_data));

   // =========================================================
   // clock, pulse counters, watchdog
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (file_rd === 1'b1) n_rd++;
      if (file_wr === 1'b1) n_wr++;
      if (wdt_clear === 1'b1) n_wdt++;
   end

   initial begin
      #200000;
      errors++;
      print_verdict();
   end

   // =========================================================
   // shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) errors++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // =========================================================
   // tests
   initial begin
      errors = 0; total_checks = 0; n_rd = 0; n_wr = 0; n_wdt = 0;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; port_pins = 8'ha5; wake = 1'b0;
      // only the bench fills the model, so no start-up race over its contents
      for (int i = 0; i < 2048; i++) pm.mem[i] = NOP_WORD;
      for (int i = 0; i < 18; i++) pm.mem[i] = prog[i];
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;

      apb(1'b0, REG_STAT, 32'h0);
      check("stat reset", rd, 32'h0000_0018);
      apb(1'b0, REG_CTRL, 32'h0);
      check("ctrl reset", rd, 32'h0);
      apb(1'b1, REG_STAT, 32'hffff_ffff);
      apb(1'b0, REG_STAT, 32'h0);
      check("stat read only", rd, 32'h0000_0018);
      apb(1'b0, 8'h08, 32'h0);
      check("unmapped err", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      $display("test registers done");

      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_CTRL, 32'h0);
      check("ctrl run", rd, 32'h1);
      n = 0;
      while (asleep !== 1'b1 && n < 1000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 1000) errors++;
      repeat (8) @(posedge pclk);
      apb(1'b0, REG_STAT, 32'h0);
      check("acc flags standby", rd & 32'h0000_ff3f, 32'h0000_3c37);
      check("port latch", {24'h0, port_out}, 32'h0000_00a7);
      check("watchdog pulses", n_wdt, 32'd1);
      check("file reads", n_rd, 32'd9);
      check("file writes", n_wr, 32'd5);
      $display("test program done");

      @(posedge pclk);
      wake <= 1'b1;
      @(posedge pclk);
      wake <= 1'b0;
      repeat (40) @(posedge pclk);
      check("awake", {31'h0, asleep}, 32'h0);
      apb(1'b0, REG_STAT, 32'h0);
      check("stat awake", rd & 32'h0000_ff3f, 32'h0000_3c17);
      check("watchdog after wake", n_wdt, 32'd1);
      $display("test wake done");
      print_verdict();
   end
endmodule
